// ==== dpi_defines.vh ====
/*
  Register map, field positions, reset values and codes shared by the
  digital I/O block and its pattern unit.
  Assumes a 32-bit APB with 12-bit byte addresses; one word per register.
*/
`ifndef DPI_DEFINES_VH
`define DPI_DEFINES_VH

// ============================================================
// Register byte offsets
`define DPI_OFF_BD0_DATA   12'h000
`define DPI_OFF_BD1_DATA   12'h004
`define DPI_OFF_OUT0_DATA  12'h008
`define DPI_OFF_OUT1_DATA  12'h00c
`define DPI_OFF_IN0_DATA   12'h010
`define DPI_OFF_IN1_DATA   12'h014
`define DPI_OFF_DIR        12'h018
`define DPI_OFF_BIT        12'h01c
`define DPI_OFF_PAT0_CFG   12'h020
`define DPI_OFF_PAT0_REF   12'h024
`define DPI_OFF_PAT1_CFG   12'h030
`define DPI_OFF_PAT1_REF   12'h034
`define DPI_OFF_IRQ_STAT   12'h040
`define DPI_OFF_IRQ_MASK   12'h044

// ============================================================
// Field positions
`define DPI_CFG_EN         0
`define DPI_CFG_SRC        1
`define DPI_BIT_VAL        0
`define DPI_BIT_IDX_LSB    4
`define DPI_BIT_PORT_LSB   8
`define DPI_BIT_PORT_MSB   10
`define DPI_BIT_WE         12
`define DPI_IRQ_PAT_LSB    0
`define DPI_IRQ_OVL_LSB    4

// ============================================================
// Codes
`define DPI_SRC_MATCH      1'b0
`define DPI_SRC_CHANGE     1'b1
`define DPI_PORT_LAST      3'h5

// ============================================================
// Reset values
`define DPI_RST_BYTE       8'h00
`define DPI_RST_WORD       32'h0000_0000
`define DPI_RST_DIR        16'h0000
`define DPI_RST_CFG        4'h0

`endif

// ==== dpi_pattern_unit.v ====
/*
  Pattern recognition for one 8-bit input-only port: match against a
  reference value, or toggle detection on the bits the reference masks.
  Assumes i_data is already synchronised to i_clk.
*/
`timescale 1ns/10ps
`include "dpi_defines.vh"

module dpi_pattern_unit
(
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_enable,
  input  wire       i_source,
  input  wire [7:0] i_reference,
  input  wire [7:0] i_data,
  output reg        o_event
);

  // ============================================================
  // Compare logic
  reg  [7:0] prev_q;
  reg        match_q;
  wire       match_now;
  wire       toggled;
  wire       is_match_mode;

  assign is_match_mode = (i_source == `DPI_SRC_MATCH);
  // Equality with the reference value
  assign match_now = (i_data == i_reference);
  // Only bits whose reference bit is one may report a toggle
  assign toggled = |((i_data ^ prev_q) & i_reference);

  // ============================================================
  // Event generation
  // match_q is cleared while disabled, so enabling on a standing match
  // counts as entry and fires once.
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prev_q  <= `DPI_RST_BYTE;
      match_q <= 1'b0;
      o_event <= 1'b0;
    end
    else
    begin
      prev_q  <= i_data;
      match_q <= i_enable && is_match_mode && match_now;
      if (!i_enable)
        o_event <= 1'b0;
      else if (is_match_mode)
        o_event <= match_now && !match_q;
      else
        o_event <= toggled;
    end
  end

endmodule

// ==== dpi_top.v ====
/*
  Digital I/O block: two bidirectional 8-bit ports, two input-only and
  two output-only 8-bit ports, pattern interrupts on the input-only
  ports and overload interrupts on the output-only ports, on APB.
  Assumes pins and overload flags are asynchronous to I_CLK; a bidir
  pin is driven only while its output enable is high.
*/
// Our own choices: the placing of the registers and the APB register port.
// Overview of operation
// - Each bidirectional port has a software direction bit; fixed ports have none.
// - Reset puts every bidirectional port into input, nothing driven.
// - Reading a port set as output returns the value being driven.
// - Ports can be read and written as a whole byte or as one bit.
// - Pattern interrupts exist only on the input-only ports.
// - Match mode interrupts when the port equals the reference register.
// - Change mode interrupts when any bit with mask one toggles either way.
// - Bits with mask zero are ignored; an all-ones mask watches every bit.
// - Each input port has its own enable, source select and reference.
// - Each output port raises its own interrupt on driver overload.
`timescale 1ns/10ps
`include "dpi_defines.vh"

module dpi_top
(
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [11:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire        O_PREADY,
  output wire        O_PSLVERR,
  input  wire [7:0]  I_BIDIR_PORT_FIRST,
  output wire [7:0]  O_BIDIR_PORT_FIRST,
  output wire [7:0]  O_BIDIR_PORT_FIRST_OE,
  input  wire [7:0]  I_BIDIR_PORT_SECOND,
  output wire [7:0]  O_BIDIR_PORT_SECOND,
  output wire [7:0]  O_BIDIR_PORT_SECOND_OE,
  input  wire [7:0]  I_ISO_INPUT_PORT_FIRST,
  input  wire [7:0]  I_ISO_INPUT_PORT_SECOND,
  output wire [7:0]  O_ISO_OUTPUT_PORT_FIRST,
  output wire [7:0]  O_ISO_OUTPUT_PORT_SECOND,
  input  wire [1:0]  I_OVERLOAD,
  output wire        O_IRQ
);

  // ============================================================
  // Declarations
  reg  [33:0] sync1_q;
  reg  [33:0] sync2_q;
  reg  [1:0]  ovl_prev_q;
  reg  [31:0] drv_q;
  reg  [31:0] drv_d;
  reg  [15:0] oe_q;
  reg  [2:0]  bit_port_q;
  reg  [2:0]  bit_idx_q;
  reg  [3:0]  pat_cfg_q;
  reg  [15:0] pat_ref_q;
  reg  [7:0]  stat_q;
  reg  [7:0]  stat_d;
  reg  [7:0]  mask_q;
  reg         irq_q;
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [31:0] rd_d;
  reg         err_d;
  wire        wr_en;
  wire [7:0]  bd0_in;
  wire [7:0]  bd1_in;
  wire [15:0] iso_in;
  wire [1:0]  ovl_lvl;
  wire [1:0]  ovl_evt;
  wire [1:0]  pat_evt;
  wire [47:0] pv;
  wire        pv_bit;
  wire [7:0]  evt;
  wire [7:0]  clr;
  wire [1:0]  dir;

  // ============================================================
  // Pin synchronisers
  // Two stages per pin; only the second stage is read by logic.
  always @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sync1_q <= 34'h0;
      sync2_q <= 34'h0;
    end
    else
    begin
      sync1_q <= {I_OVERLOAD, I_ISO_INPUT_PORT_SECOND,
                  I_ISO_INPUT_PORT_FIRST, I_BIDIR_PORT_SECOND,
                  I_BIDIR_PORT_FIRST};
      sync2_q <= sync1_q;
    end
  end

  assign bd0_in  = sync2_q[7:0];
  assign bd1_in  = sync2_q[15:8];
  assign iso_in  = sync2_q[31:16];
  assign ovl_lvl = sync2_q[33:32];

  // ============================================================
  // Port views for reads
  // Direction lives in the replicated output enables.
  assign dir = {oe_q[8], oe_q[0]};
  // Output ports return what is driven, input ports the pin level
  assign pv = {iso_in,
               drv_q[31:16],
               (dir[1] ? drv_q[15:8] : bd1_in),
               (dir[0] ? drv_q[7:0] : bd0_in)};
  // Single bit view; codes above the last port read as zero
  assign pv_bit = (bit_port_q <= `DPI_PORT_LAST) ?
                  pv[{bit_port_q, bit_idx_q}] : 1'b0;

  // ============================================================
  // Pattern units, one per input-only port only
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_pat
      dpi_pattern_unit u_pat
      (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_enable    (pat_cfg_q[2*g+`DPI_CFG_EN]),
        .i_source    (pat_cfg_q[2*g+`DPI_CFG_SRC]),
        .i_reference (pat_ref_q[8*g+7:8*g]),
        .i_data      (iso_in[8*g+7:8*g]),
        .o_event     (pat_evt[g])
      );
    end
  endgenerate

  // ============================================================
  // Overload edge detect
  // An overload that stays asserted raises one event, not a stream.
  always @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      ovl_prev_q <= 2'b00;
    else
      ovl_prev_q <= ovl_lvl;
  end

  assign ovl_evt = ovl_lvl & ~ovl_prev_q;

  // ============================================================
  // APB write strobe
  // Writes land only at the completing access edge.
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && pready_q;

  // ============================================================
  // Output data next value: byte writes and bit writes
  always @*
  begin
    drv_d = drv_q;
    if (wr_en)
    begin
      case (I_PADDR)
        `DPI_OFF_BD0_DATA:  drv_d[7:0]   = I_PWDATA[7:0];
        `DPI_OFF_BD1_DATA:  drv_d[15:8]  = I_PWDATA[7:0];
        `DPI_OFF_OUT0_DATA: drv_d[23:16] = I_PWDATA[7:0];
        `DPI_OFF_OUT1_DATA: drv_d[31:24] = I_PWDATA[7:0];
        `DPI_OFF_BIT:
        begin
          // Bit writes to input-only codes are dropped
          if (I_PWDATA[`DPI_BIT_WE] && !I_PWDATA[`DPI_BIT_PORT_MSB])
            drv_d[{I_PWDATA[9:8], I_PWDATA[6:4]}] =
              I_PWDATA[`DPI_BIT_VAL];
        end
        default: drv_d = drv_q;
      endcase
    end
  end

  // ============================================================
  // Control registers
  always @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      drv_q      <= `DPI_RST_WORD;
      oe_q       <= `DPI_RST_DIR;
      bit_port_q <= 3'h0;
      bit_idx_q  <= 3'h0;
      pat_cfg_q  <= `DPI_RST_CFG;
      pat_ref_q  <= 16'h0000;
      mask_q     <= `DPI_RST_BYTE;
    end
    else
    begin
      drv_q <= drv_d;
      if (wr_en)
      begin
        case (I_PADDR)
          `DPI_OFF_DIR:
            oe_q <= {{8{I_PWDATA[1]}}, {8{I_PWDATA[0]}}};
          `DPI_OFF_BIT:
          begin
            bit_port_q <= I_PWDATA[10:8];
            bit_idx_q  <= I_PWDATA[6:4];
          end
          `DPI_OFF_PAT0_CFG: pat_cfg_q[1:0]  <= I_PWDATA[1:0];
          `DPI_OFF_PAT0_REF: pat_ref_q[7:0]  <= I_PWDATA[7:0];
          `DPI_OFF_PAT1_CFG: pat_cfg_q[3:2]  <= I_PWDATA[1:0];
          `DPI_OFF_PAT1_REF: pat_ref_q[15:8] <= I_PWDATA[7:0];
          `DPI_OFF_IRQ_MASK: mask_q          <= I_PWDATA[7:0];
          default:           mask_q          <= mask_q;
        endcase
      end
    end
  end

  // ============================================================
  // Interrupt status, write one to clear
  assign evt = {2'b00, ovl_evt, 2'b00, pat_evt};
  assign clr = (wr_en && (I_PADDR == `DPI_OFF_IRQ_STAT)) ?
               I_PWDATA[7:0] : 8'h00;

  // A new event in the clearing cycle survives: set beats clear.
  always @*
  begin
    stat_d = (stat_q & ~clr) | evt;
  end

  // Output is registered, so it trails the status bit by one cycle.
  always @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      stat_q <= `DPI_RST_BYTE;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  // ============================================================
  // Read decode
  // Unmapped or unaligned addresses read zero and flag PSLVERR.
  always @*
  begin
    rd_d  = `DPI_RST_WORD;
    err_d = 1'b0;
    case (I_PADDR)
      `DPI_OFF_BD0_DATA:  rd_d = {24'h000000, pv[7:0]};
      `DPI_OFF_BD1_DATA:  rd_d = {24'h000000, pv[15:8]};
      `DPI_OFF_OUT0_DATA: rd_d = {24'h000000, pv[23:16]};
      `DPI_OFF_OUT1_DATA: rd_d = {24'h000000, pv[31:24]};
      `DPI_OFF_IN0_DATA:  rd_d = {24'h000000, pv[39:32]};
      `DPI_OFF_IN1_DATA:  rd_d = {24'h000000, pv[47:40]};
      `DPI_OFF_DIR:       rd_d = {30'h0, dir};
      `DPI_OFF_BIT:
        rd_d = {15'h0, pv_bit, 5'h00, bit_port_q, 1'b0,
                bit_idx_q, 4'h0};
      `DPI_OFF_PAT0_CFG:  rd_d = {30'h0, pat_cfg_q[1:0]};
      `DPI_OFF_PAT0_REF:  rd_d = {24'h000000, pat_ref_q[7:0]};
      `DPI_OFF_PAT1_CFG:  rd_d = {30'h0, pat_cfg_q[3:2]};
      `DPI_OFF_PAT1_REF:  rd_d = {24'h000000, pat_ref_q[15:8]};
      `DPI_OFF_IRQ_STAT:  rd_d = {24'h000000, stat_q};
      `DPI_OFF_IRQ_MASK:  rd_d = {24'h000000, mask_q};
      default:            err_d = 1'b1;
    endcase
  end

  // ============================================================
  // APB answer
  // One wait-free access phase: ready rises at the edge ending setup,
  // so every transfer takes exactly setup plus one access cycle.
  always @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `DPI_RST_WORD;
    end
    else
    begin
      pready_q <= I_PSEL && !I_PENABLE;
      if (I_PSEL && !I_PENABLE)
      begin
        pslverr_q <= err_d;
        prdata_q  <= I_PWRITE ? `DPI_RST_WORD : rd_d;
      end
      else
      begin
        pslverr_q <= 1'b0;
        prdata_q  <= `DPI_RST_WORD;
      end
    end
  end

  // ============================================================
  // Outputs, all straight from flip-flops
  assign O_PRDATA                 = prdata_q;
  assign O_PREADY                 = pready_q;
  assign O_PSLVERR                = pslverr_q;
  assign O_BIDIR_PORT_FIRST       = drv_q[7:0];
  assign O_BIDIR_PORT_FIRST_OE    = oe_q[7:0];
  assign O_BIDIR_PORT_SECOND      = drv_q[15:8];
  assign O_BIDIR_PORT_SECOND_OE   = oe_q[15:8];
  assign O_ISO_OUTPUT_PORT_FIRST  = drv_q[23:16];
  assign O_ISO_OUTPUT_PORT_SECOND = drv_q[31:24];
  assign O_IRQ                    = irq_q;

endmodule

// ==== dpi_top_checker.sv ====
/*
  Checker for dpi_top: APB timing, bidir direction, readback and
  interrupt hold relations. Sees the top ports only; bound at foot.
*/
`timescale 1ns/10ps
`include "dpi_defines.vh"
module dpi_top_checker
(
  input wire        I_CLK,
  input wire        I_SYS_RST,
  input wire        I_PSEL,
  input wire        I_PENABLE,
  input wire        I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [31:0] O_PRDATA,
  input wire        O_PREADY,
  input wire        O_PSLVERR,
  input wire [7:0]  O_BIDIR_PORT_FIRST,
  input wire [7:0]  O_BIDIR_PORT_FIRST_OE,
  input wire [7:0]  O_BIDIR_PORT_SECOND_OE,
  input wire [7:0]  O_ISO_OUTPUT_PORT_FIRST,
  input wire        O_IRQ
);
  // =========================================================
  // Accepted transfer and setup cycle
  wire acc = I_PSEL & I_PENABLE & O_PREADY;
  wire stp = I_PSEL & ~I_PENABLE;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  // =========================================================
  // Pins
  AST_RST_IDLE: assert property ($fell(I_SYS_RST) |->
    {O_BIDIR_PORT_FIRST_OE, O_BIDIR_PORT_SECOND_OE} == 16'h0000)
    else $error("bidir driven after reset");
  AST_OE_WHOLE: assert property (O_BIDIR_PORT_FIRST_OE == 8'h00 ||
    O_BIDIR_PORT_FIRST_OE == 8'hff) else $error("split direction");
  AST_OE_CAUSE: assert property (!$stable(O_BIDIR_PORT_FIRST_OE) |->
    $past(acc && I_PWRITE && I_PADDR == `DPI_OFF_DIR))
    else $error("direction moved without write");
  AST_OUT_CAUSE: assert property (!$stable(O_ISO_OUTPUT_PORT_FIRST) |->
    $past(acc && I_PWRITE && (I_PADDR == `DPI_OFF_OUT0_DATA ||
    I_PADDR == `DPI_OFF_BIT))) else $error("output moved without write");
  // Readback shows the state at the setup edge
  AST_RD_OUT: assert property (acc && !I_PWRITE &&
    I_PADDR == `DPI_OFF_OUT0_DATA |->
    O_PRDATA == {24'h0, $past(O_ISO_OUTPUT_PORT_FIRST)})
    else $error("output readback wrong");
  AST_RD_BIDIR: assert property (acc && !I_PWRITE &&
    I_PADDR == `DPI_OFF_BD0_DATA && $past(O_BIDIR_PORT_FIRST_OE[0]) |->
    O_PRDATA == {24'h0, $past(O_BIDIR_PORT_FIRST)})
    else $error("bidir readback wrong");

  // =========================================================
  // Bus
  AST_READY_ONE: assert property (stp |=> O_PREADY ##1 !O_PREADY)
    else $error("ready not a one cycle answer");
  AST_ERR_ALIGN: assert property (stp && I_PADDR[1:0] != 2'b00 |=>
    O_PSLVERR && O_PREADY) else $error("unaligned not refused");
  AST_IDLE_ZERO: assert property (!O_PREADY |->
    O_PRDATA == 32'h0 && !O_PSLVERR) else $error("bus outputs not idle");

  // =========================================================
  // Interrupt
  AST_IRQ_HOLD: assert property ($fell(O_IRQ) |-> $past(acc && I_PWRITE
    && (I_PADDR == `DPI_OFF_IRQ_STAT || I_PADDR == `DPI_OFF_IRQ_MASK), 2))
    else $error("interrupt dropped on its own");
  AST_MASK_OFF: assert property (acc && I_PWRITE &&
    I_PADDR == `DPI_OFF_IRQ_MASK && I_PWDATA[5:0] == 6'h00 |-> ##2 !O_IRQ)
    else $error("masked interrupt still high");
  CV_IRQ: cover property (O_IRQ);
  CV_ERR: cover property (O_PSLVERR);
  CV_DRIVE: cover property ($rose(O_BIDIR_PORT_FIRST_OE[0]));
endmodule

bind dpi_top dpi_top_checker chk_u
(
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_BIDIR_PORT_FIRST(O_BIDIR_PORT_FIRST),
  .O_BIDIR_PORT_FIRST_OE(O_BIDIR_PORT_FIRST_OE),
  .O_BIDIR_PORT_SECOND_OE(O_BIDIR_PORT_SECOND_OE),
  .O_ISO_OUTPUT_PORT_FIRST(O_ISO_OUTPUT_PORT_FIRST), .O_IRQ(O_IRQ)
);

// ==== dpi_field_model.sv ====
/*
  Field wiring on one bidir port: the device wins on a line it drives,
  elsewhere the bench's external level shows. No pull resistors.
*/
`timescale 1ns/10ps
module dpi_field_model
(
  input  wire [7:0] i_oe,
  input  wire [7:0] i_drive,
  input  wire [7:0] i_ext,
  output wire [7:0] o_pin
);
  // Resolve each line from the device's enable alone
  assign o_pin = (i_oe & i_drive) | (~i_oe & i_ext);
endmodule

// ==== dpi_top_bench.sv ====
/*
  Self-checking bench for dpi_top: APB master tasks, field model on
  the bidir pins, seeded random data. Expects the bound checker.
*/
`timescale 1ns/10ps
`include "dpi_defines.vh"
module dpi_top_bench;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, irq, rerr, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0]  ext0, ext1, pin0, pin1, q0, q1, oe0, oe1, in0, in1;
  logic [7:0]  do0, do1, v;
  logic [1:0]  ovl;
  integer      seed, err_count, num_checks, i;

  // =========================================================
  // Clock, design and field wiring
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dpi_top dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_BIDIR_PORT_FIRST(pin0), .O_BIDIR_PORT_FIRST(q0),
    .O_BIDIR_PORT_FIRST_OE(oe0), .I_BIDIR_PORT_SECOND(pin1),
    .O_BIDIR_PORT_SECOND(q1), .O_BIDIR_PORT_SECOND_OE(oe1),
    .I_ISO_INPUT_PORT_FIRST(in0), .I_ISO_INPUT_PORT_SECOND(in1),
    .O_ISO_OUTPUT_PORT_FIRST(do0), .O_ISO_OUTPUT_PORT_SECOND(do1),
    .I_OVERLOAD(ovl), .O_IRQ(irq));
  dpi_field_model f0_u (.i_oe(oe0), .i_drive(q0), .i_ext(ext0), .o_pin(pin0));
  dpi_field_model f1_u (.i_oe(oe1), .i_drive(q1), .i_ext(ext1), .o_pin(pin1));

  // =========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task final_report;
    begin
      if (err_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // One transfer; request held until ready is seen, then released
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      chk("ready", {31'h0, pready}, 32'h1);
      if (n >= 20)
        final_report;
    end
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(n, rdata, e);
    end
  endtask
  // Clear status bits, then let the registered line fall before reuse
  task automatic clr_irq(input logic [31:0] m);
    begin
      apb(1'b1, `DPI_OFF_IRQ_STAT, m);
      repeat (2) @(posedge clk);
      chk("irq clr", {31'h0, irq}, 32'h0);
    end
  endtask
  // Bounded wait for the interrupt line; returns once it is seen high
  task automatic wait_irq;
    integer n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 30)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk("irq", {31'h0, irq}, 32'h1);
      if (n >= 30)
        final_report;
    end
  endtask

  // =========================================================
  // Watchdog; a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    final_report;
  end

  // =========================================================
  // Main sequence
  initial
  begin
    seed = 32'ha03f;
    err_count = 0;
    num_checks = 0;
    {psel, pen, pwr, paddr, pwdata, ovl} = '0;
    {ext0, ext1, in0, in1} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe", {oe0, oe1}, 32'h0);
    rd("dir", `DPI_OFF_DIR, 32'h0);
    // Byte writes on both output-only ports, readback on the first
    for (i = 0; i < 4; i = i + 1)
    begin
      v = $random(seed);
      apb(1'b1, `DPI_OFF_OUT0_DATA, {24'h0, v});
      apb(1'b1, `DPI_OFF_OUT1_DATA, {24'h0, ~v});
      @(negedge clk);
      chk("out pins", {do0, do1}, {v, ~v});
      rd("out0", `DPI_OFF_OUT0_DATA, {24'h0, v});
    end
    // Single-bit writes through the bit register, every index
    for (i = 0; i < 8; i = i + 1)
    begin
      b = $random(seed);
      v[i] = b;
      apb(1'b1, `DPI_OFF_BIT, 32'h1200 | (i << 4) | b);
      @(negedge clk);
      chk("bit out", do0, v);
      rd("bit rd", `DPI_OFF_BIT, (b << 16) | 32'h200 | (i << 4));
    end
    // First bidir as output, second stays input
    v = $random(seed);
    ext0 <= ~v;
    ext1 <= $random(seed);
    apb(1'b1, `DPI_OFF_DIR, 32'h1);
    apb(1'b1, `DPI_OFF_BD0_DATA, {24'h0, v});
    apb(1'b1, `DPI_OFF_BD1_DATA, {24'h0, ~v});
    @(negedge clk);
    chk("oe dir", {oe0, oe1, q0, q1}, {8'hff, 8'h00, v, ~v});
    rd("bd0", `DPI_OFF_BD0_DATA, {24'h0, v});
    rd("bd1", `DPI_OFF_BD1_DATA, {24'h0, ext1});
    apb(1'b1, `DPI_OFF_DIR, 32'h0);
    repeat (2) @(posedge clk);
    rd("bd0 in", `DPI_OFF_BD0_DATA, {24'h0, ~v});
    // Match on first input port: sticky, once per entry
    v = $random(seed) | 8'h01;
    apb(1'b1, `DPI_OFF_IRQ_MASK, 32'h33);
    apb(1'b1, `DPI_OFF_PAT0_REF, {24'h0, v});
    apb(1'b1, `DPI_OFF_PAT0_CFG, 32'h1);
    in0 <= v;
    wait_irq;
    in0 <= ~v;
    repeat (8) @(posedge clk);
    rd("stat hold", `DPI_OFF_IRQ_STAT, 32'h1);
    clr_irq(32'h1);
    in0 <= v;
    wait_irq;
    apb(1'b1, `DPI_OFF_IRQ_STAT, 32'h1);
    repeat (8) @(posedge clk);
    rd("no refire", `DPI_OFF_IRQ_STAT, 32'h0);
    apb(1'b1, `DPI_OFF_PAT0_CFG, 32'h0);
    // Change mode on second input port with a low-nibble mask
    apb(1'b1, `DPI_OFF_PAT1_REF, 32'h0f);
    apb(1'b1, `DPI_OFF_PAT1_CFG, 32'h3);
    in1 <= 8'hf0;
    repeat (8) @(posedge clk);
    rd("masked", `DPI_OFF_IRQ_STAT, 32'h0);
    for (i = 0; i < 2; i = i + 1)
    begin
      in1 <= in1 ^ 8'h04;
      wait_irq;
      rd("change", `DPI_OFF_IRQ_STAT, 32'h2);
      clr_irq(32'h2);
    end
    apb(1'b1, `DPI_OFF_PAT1_REF, 32'hff);
    in1 <= in1 ^ 8'h80;
    wait_irq;
    clr_irq(32'h2);
    // Overload on second output port, then masked and cleared
    ovl <= 2'b10;
    wait_irq;
    apb(1'b1, `DPI_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd("ovl stat", `DPI_OFF_IRQ_STAT, 32'h20);
    apb(1'b1, `DPI_OFF_IRQ_STAT, 32'h20);
    rd("cleared", `DPI_OFF_IRQ_STAT, 32'h0);
    // Refused and read-only places
    apb(1'b0, 12'h002, 32'h0);
    chk("unaligned", {31'h0, rerr}, 32'h1);
    chk("unaligned data", rdata, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    apb(1'b1, `DPI_OFF_IN0_DATA, 32'hff);
    chk("ro write", {31'h0, rerr}, 32'h0);
    rd("in0", `DPI_OFF_IN0_DATA, {24'h0, in0});
    final_report;
  end
endmodule
